/* File: design/pps_pkg.sv */
package pps_pkg;
   // Number of ports handled by the controller.
   localparam int NUM_PORTS = 4;
   // Width of each port configuration byte.
   localparam int CFG_WIDTH = 8;
   // Bit position of the priority field in a configuration byte.
   localparam int PRIO_BIT = 4;
   // Priority field value that marks a port as low priority.
   localparam logic PRIO_LOW = 1'h1;
   // Minimum shutdown pulse width in nanoseconds.
   localparam int PORT_SHUTDOWN_INPUT_MIN_NS = 5000;
   // Clock period in nanoseconds.
   localparam int CLK_PERIOD_NS = 8;
   // Minimum pulse in clock cycles, rounded up.
   localparam int PORT_SHUTDOWN_INPUT_MIN_CYC =
      (PORT_SHUTDOWN_INPUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Width of the pulse qualification counter.
   localparam int QUAL_W = $clog2(PORT_SHUTDOWN_INPUT_MIN_CYC + 1);
   // Qualifier states, one-hot.
   typedef enum logic [1:0] {
      PPS_IDLE = 2'h1,
      PPS_ACTIVE = 2'h2
   } pps_state_t;
endpackage

/* File: design/pps_port_priority_shutdown.sv */
module pps_port_priority_shutdown
   import pps_pkg::*;
(
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rst_in,
   // Active-low shutdown request from the board.
   input wire logic port_shutdown_input_n_in,
   // Per-port configuration bytes, port i at bits [8i+7:8i].
   input wire logic [NUM_PORTS*CFG_WIDTH-1:0] port_cfg_in,
   // Per-port power state from the port controllers.
   input wire logic [NUM_PORTS-1:0] port_powered_in,
   // Forced turn-off per port.
   output logic [NUM_PORTS-1:0] port_force_off_out,
   // Power-on inhibit per port.
   output logic [NUM_PORTS-1:0] port_power_inhibit_out,
   // Clear of detect and classify enables per port.
   output logic [NUM_PORTS-1:0] det_cls_clear_out,
   // Qualified shutdown level.
   output logic shutdown_active_out
);

   logic sync1_r;
   logic sync2_r;
   logic [QUAL_W-1:0] qual_cnt_r;
   logic [QUAL_W-1:0] qual_cnt_nxt;
   pps_state_t state_r;
   pps_state_t state_nxt;
   logic [NUM_PORTS-1:0] affected_r;
   logic [NUM_PORTS-1:0] affected_nxt;
   logic [NUM_PORTS-1:0] low_prio;
   logic [NUM_PORTS-1:0] first_hit;
   wire pin_low = ~sync2_r;
   wire qual_done = (qual_cnt_r == QUAL_W'(PORT_SHUTDOWN_INPUT_MIN_CYC - 1));
   wire entering = (state_r == PPS_IDLE) && pin_low && qual_done;
   wire active = (state_r == PPS_ACTIVE);

   // Two-flop synchroniser; the pin is idle high, so reset to one.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_r <= 1'h1;
         sync2_r <= 1'h1;
      end else begin
         sync1_r <= port_shutdown_input_n_in;
         sync2_r <= sync1_r;
      end
   end

   // Extract priority bits per port.
   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g++) begin : g_prio
         assign low_prio[g] =
            (port_cfg_in[g*CFG_WIDTH+PRIO_BIT] == PRIO_LOW);
      end
   endgenerate

   // Only ports that are on at the moment the pulse qualifies are captured.
   assign first_hit = low_prio & port_powered_in;

   // Counter saturates so a long low does not wrap and re-trigger.
   // The count starts only once the synchronised level is low, so the
   // two synchroniser stages add latency but never shorten the span.
   // A slower clock would need the package period changed to match.
   assign qual_cnt_nxt = !pin_low ? '0 :
      (qual_done ? qual_cnt_r : qual_cnt_r + QUAL_W'(1));

   // Enter on a qualified pulse, leave as soon as the pin releases.
   always_comb begin
      state_nxt = state_r;
      affected_nxt = affected_r;
      case (state_r)
         PPS_IDLE: begin
            affected_nxt = '0;
            if (entering) begin
               state_nxt = PPS_ACTIVE;
               affected_nxt = first_hit;
            end
         end
         PPS_ACTIVE: begin
            if (!pin_low) begin
               state_nxt = PPS_IDLE;
               affected_nxt = '0;
            end
         end
         default: begin
            state_nxt = PPS_IDLE;
            affected_nxt = '0;
         end
      endcase
   end

   // State, counter and captured port set.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= PPS_IDLE;
         qual_cnt_r <= '0;
         affected_r <= '0;
      end else begin
         state_r <= state_nxt;
         qual_cnt_r <= qual_cnt_nxt;
         affected_r <= affected_nxt;
      end
   end

   // Port outputs are registered copies of the captured set; the status output copies the state.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         port_force_off_out <= '0;
         port_power_inhibit_out <= '0;
         det_cls_clear_out <= '0;
         shutdown_active_out <= 1'h0;
      end else begin
         port_force_off_out <= affected_nxt;
         port_power_inhibit_out <= affected_nxt;
         det_cls_clear_out <= affected_nxt;
         shutdown_active_out <= (state_nxt == PPS_ACTIVE);
      end
   end

   // Checks. The outputs are registered, so most of them are judged
   // one edge after the state that produced them.

   // A level shorter than the qualifying span must never open the gate.
   AST_GLITCH: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (state_r == PPS_IDLE && !qual_done) |=> state_r == PPS_IDLE)
      else $error("Shutdown entered before pulse qualified.");

   // On entry, exactly the powered low-priority ports are turned off.
   AST_ENTER: assert property (
      @(posedge clock_in) disable iff (rst_in)
      entering |=> port_force_off_out == $past(first_hit))
      else $error("Powered low-priority ports not switched off.");

   // A port marked high priority is never forced off.
   AST_HIGH_PRIO: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (port_force_off_out & ~$past(low_prio)) == '0)
      else $error("A high-priority port was forced off.");

   // While the pin stays low, the inhibit follows the captured set.
   AST_HOLD: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (active && pin_low) |=> port_power_inhibit_out == affected_r)
      else $error("Inhibit dropped while shutdown still asserted.");

   // Enable clears go to the same ports that are forced off.
   AST_CLEAR: assert property (
      @(posedge clock_in) disable iff (rst_in)
      det_cls_clear_out == port_force_off_out)
      else $error("Enable clear not matching forced ports.");

   // A released pin ends the shutdown at the next edge.
   AST_RELEASE: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (active && !pin_low) |=> !shutdown_active_out
         && port_force_off_out == '0)
      else $error("Shutdown not released with the pin.");

   // Two synchroniser stages: three low samples give a low level.
   AST_SYNC: assert property (
      @(posedge clock_in) disable iff (rst_in)
      !port_shutdown_input_n_in [*3] |=> pin_low)
      else $error("Synchroniser latency wrong.");

   // Any high level restarts qualification from zero.
   AST_QUAL: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (!pin_low) |=> qual_cnt_r == '0)
      else $error("Counter not reset on high level.");

   // The qualifier state always holds one legal one-hot code.
   AST_ONEHOT: assert property (
      @(posedge clock_in) disable iff (rst_in)
      $onehot(state_r))
      else $error("Qualifier state not one-hot.");

   // Inhibit and forced turn-off always cover the same ports.
   AST_INHIBIT: assert property (
      @(posedge clock_in) disable iff (rst_in)
      port_power_inhibit_out == port_force_off_out)
      else $error("Inhibit differs from forced ports.");

   // The status output mirrors the qualifier state.
   AST_ACTIVE_OUT: assert property (
      @(posedge clock_in) disable iff (rst_in)
      shutdown_active_out == active)
      else $error("Shutdown status differs from state.");

   // The counter saturates at the last qualifying count.
   AST_CNT_MAX: assert property (
      @(posedge clock_in) disable iff (rst_in)
      qual_cnt_r <= QUAL_W'(PORT_SHUTDOWN_INPUT_MIN_CYC - 1))
      else $error("Qualifier counter ran past its limit.");

   // The captured set does not change while the pin stays low.
   AST_FROZEN: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (active && pin_low) |=> $stable(port_force_off_out))
      else $error("Forced set changed during shutdown.");

   // Outside a shutdown no port is touched at all.
   AST_IDLE_QUIET: assert property (
      @(posedge clock_in) disable iff (rst_in)
      !active |-> port_force_off_out == '0)
      else $error("Port forced off while idle.");

   // A port that was off at entry is never captured.
   AST_UNPOWERED: assert property (
      @(posedge clock_in) disable iff (rst_in)
      entering |=> (port_force_off_out & ~$past(port_powered_in)) == '0)
      else $error("An unpowered port was forced off.");

   // Main scenarios: entry, release, a rejected glitch, a held shutdown.
   COV_ENTER: cover property (@(posedge clock_in) entering);
   COV_RELEASE: cover property (@(posedge clock_in) active && !pin_low);
   COV_GLITCH: cover property (@(posedge clock_in)
      pin_low ##1 !pin_low && state_r == PPS_IDLE);
   COV_HOLD: cover property (@(posedge clock_in)
      (active && pin_low) [*8]);
endmodule

/* File: tb/pps_port_model.sv */
module pps_port_model
   import pps_pkg::*;
(
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rst_in,
   // Requests and controls per port.
   input wire logic [NUM_PORTS-1:0] turn_on_in,
   input wire logic [NUM_PORTS-1:0] force_off_in,
   input wire logic [NUM_PORTS-1:0] inhibit_in,
   // Port power state.
   output logic [NUM_PORTS-1:0] powered_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // A port comes up on request; a forced port drops and stays down.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         powered_out <= '0;
      end else begin
         powered_out <= (powered_out | turn_on_in) &
            ~(force_off_in | inhibit_in);
      end
   end
endmodule

/* File: tb/pps_port_priority_shutdown_bench.sv */
module pps_port_priority_shutdown_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import pps_pkg::*;
   logic clock_in = 0, rst_in = 1, pin_n = 1;
   logic [31:0] cfg = {8'hFF, 8'h13, 8'h0F, 8'h10};
   logic [3:0] on_req = 4'h0, pwr, fo, inh, clr;
   logic act;
   int miscompares = 0, checks = 0;
   pps_port_priority_shutdown u_dut (.clock_in(clock_in), .rst_in(rst_in),
      .port_shutdown_input_n_in(pin_n), .port_cfg_in(cfg),
      .port_powered_in(pwr), .port_force_off_out(fo),
      .port_power_inhibit_out(inh), .det_cls_clear_out(clr),
      .shutdown_active_out(act));
   pps_port_model u_model (.clock_in(clock_in), .rst_in(rst_in),
      .turn_on_in(on_req), .force_off_in(fo), .inhibit_in(inh),
      .powered_out(pwr));
   // Free-running system clock.
   initial begin
      forever #4 clock_in = ~clock_in;
   end
   // Inputs move 1 ns after the edge so sampling never races.
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // A pulse 25 cycles under the minimum width must be ignored.
   task automatic short_pulse;
      pin_n = 0;
      cyc(600);
      pin_n = 1;
      cyc(40);
      chk({act, fo, inh, clr}, 13'h0);
   endtask
   // Ports 0,3 are low priority and on; 1 is high, 2 is low but off.
   task automatic qualified_shutdown;
      on_req = 4'hB;
      cyc(2);
      on_req = 4'h0;
      chk({9'h0, pwr}, 13'h00B);
      pin_n = 0;
      cyc(615);
      chk({act, fo, inh, clr}, 13'h0);
      cyc(20);
      chk({act, fo, inh, clr}, {1'h1, 4'h9, 4'h9, 4'h9});
      chk({9'h0, pwr}, 13'h002);
      // Captured ports stay off; port 2, off at entry, is not captured.
      on_req = 4'hD;
      cyc(3);
      on_req = 4'h0;
      chk({9'h0, pwr}, 13'h006);
      chk({act, fo, inh, clr}, {1'h1, 4'h9, 4'h9, 4'h9});
      pin_n = 1;
      cyc(6);
      chk({act, fo, inh, clr}, 13'h0);
   endtask
   // Guard against a hung run.
   initial begin
      repeat (5000) @(posedge clock_in);
      miscompares++;
      print_verdict();
   end
   initial begin
      cyc(5);
      rst_in = 0;
      cyc(2);
      short_pulse();
      qualified_shutdown();
      print_verdict();
   end
endmodule
